// ==== pkg/fps_pkg.sv ====
package fps_pkg;

    // Clock
    localparam int CLK_NS = 10;
    localparam int CLK_MHZ = 100;

    // Bus timing, ns, rounded up to whole cycles
    localparam int T_WP_NS = 90;
    localparam int T_WPH_NS = 90;
    localparam int T_ACC_NS = 90;
    localparam int STROBE_HIGH_PULSE_MIN_NS = 150;
    localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] OEHP_CYC = 8'((STROBE_HIGH_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS);

    // Longest internal operation times, rounded down
    localparam int BYTE_PROGRAM_DURATION_MAX_US = 50;
    localparam int ERASE_DURATION_MAX_S = 10;
    localparam int PROG_TIMEOUT_CYC = BYTE_PROGRAM_DURATION_MAX_US * CLK_MHZ;
    localparam int ERASE_TIMEOUT_CYC = ERASE_DURATION_MAX_S * 1000000 * CLK_MHZ;

    // Geometry
    localparam int ADDR_W = 18;
    localparam logic [17:0] BOOT_BLOCK_FIRST = 18'h00000;
    localparam logic [17:0] BOOT_BLOCK_LAST = 18'h01FFF;
    localparam int TOGGLE_BIT = 6;
    localparam int POLL_BIT = 7;

    // Command sequence words, address on the low fifteen lines
    localparam logic [17:0] CMD_ADDR_A = 18'h05555;
    localparam logic [17:0] CMD_ADDR_B = 18'h02AAA;
    localparam logic [7:0] KEY_A = 8'hAA;
    localparam logic [7:0] KEY_B = 8'h55;
    localparam logic [7:0] CODE_PROGRAM = 8'hA0;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CODE_ERASE_CHIP = 8'h10;
    localparam logic [7:0] CODE_ID_ENTER = 8'h90;
    localparam logic [7:0] CODE_ID_EXIT = 8'hF0;
    localparam logic [7:0] CODE_BOOT_LOCK = 8'h40;
    localparam logic [17:0] ID_BASE_ADDR = 18'h00000;

    typedef enum logic [2:0] {
        FPS_OP_READ = 3'h0,
        FPS_OP_PROGRAM = 3'h1,
        FPS_OP_ERASE = 3'h2,
        FPS_OP_ID_ENTER = 3'h3,
        FPS_OP_ID_EXIT = 3'h4,
        FPS_OP_BOOT_LOCK = 3'h5,
        FPS_OP_ID_READ = 3'h6
    } fps_op_t;

    typedef struct packed {
        fps_op_t op;
        logic [17:0] addr;
        logic [7:0] data;
    } fps_cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic error;
    } fps_resp_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [17:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
    } fps_pins_t;

endpackage : fps_pkg

// ==== rtl/fps_bus_cycle.sv ====
`timescale 1ns/1ps
module fps_bus_cycle (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic is_write,
    input wire logic oe_park_low,
    input wire logic [17:0] addr,
    input wire logic [7:0] wdata,
    // Answer
    output logic done,
    output logic [7:0] rdata,
    // Flash pins
    input wire logic [7:0] dq_in,
    output fps_pkg::fps_pins_t pins
);
    typedef enum logic [1:0] {
        FPS_BC_IDLE = 2'b00,
        FPS_BC_SETUP = 2'b01,
        FPS_BC_STROBE = 2'b11,
        FPS_BC_GAP = 2'b10
    } fps_bc_st_t;

    typedef struct packed {
        fps_bc_st_t st;
        logic [7:0] cnt;
        logic write;
        fps_pkg::fps_pins_t pins;
        logic [7:0] rdata;
        logic done;
    } fps_bc_t;

    fps_bc_t s;
    fps_bc_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            FPS_BC_IDLE: begin
                // Output gate parks low while an erase sequence is in flight
                next_s.pins.oe_n = ~oe_park_low;
                next_s.pins.ce_n = 1'b1;
                next_s.pins.we_n = 1'b1;
                next_s.pins.dq_oe = 1'b0;
                if (start) begin
                    next_s.st = FPS_BC_SETUP;
                    next_s.write = is_write;
                    next_s.pins.addr = addr;
                    next_s.pins.dq_out = wdata;
                    if (!is_write) begin
                        next_s.pins.ce_n = 1'b0;
                        next_s.pins.oe_n = 1'b0;
                    end
                end
            end
            FPS_BC_SETUP: begin
                next_s.st = FPS_BC_STROBE;
                if (s.write) begin
                    // Chip select and write strobe fall together; in an erase the gate is high only then
                    next_s.pins.ce_n = 1'b0;
                    next_s.pins.we_n = 1'b0;
                    next_s.pins.oe_n = 1'b1;
                    next_s.pins.dq_oe = 1'b1;
                    next_s.cnt = fps_pkg::WP_CYC - 8'h01;
                end else begin
                    next_s.cnt = fps_pkg::ACC_CYC - 8'h01;
                end
            end
            FPS_BC_STROBE: begin
                if (s.cnt != 8'h00) begin
                    next_s.cnt = s.cnt - 8'h01;
                end else begin
                    next_s.st = FPS_BC_GAP;
                    next_s.pins.ce_n = 1'b1;
                    next_s.pins.we_n = 1'b1;
                    next_s.pins.dq_oe = 1'b0;
                    next_s.pins.oe_n = s.write ? ~oe_park_low : 1'b1;
                    if (s.write) begin
                        next_s.cnt = fps_pkg::WPH_CYC - 8'h01;
                    end else begin
                        next_s.rdata = dq_in;
                        // Strobes stay high long enough between status reads
                        next_s.cnt = fps_pkg::OEHP_CYC - 8'h01;
                    end
                end
            end
            FPS_BC_GAP: begin
                if (s.cnt != 8'h00) begin
                    next_s.cnt = s.cnt - 8'h01;
                end else begin
                    next_s.st = FPS_BC_IDLE;
                    next_s.done = 1'b1;
                end
            end
            default: begin
                next_s.st = FPS_BC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '{st: FPS_BC_IDLE, cnt: 8'h00, write: 1'b0,
                   pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 18'h00000,
                           dq_out: 8'h00, dq_oe: 1'b0},
                   rdata: 8'h00, done: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;
    assign rdata = s.rdata;
    assign pins = s.pins;

endmodule : fps_bus_cycle

// ==== rtl/fps_host.sv ====
`timescale 1ns/1ps
module fps_host #(
    parameter int PROG_TIMEOUT = fps_pkg::PROG_TIMEOUT_CYC,
    parameter int ERASE_TIMEOUT = fps_pkg::ERASE_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Command
    input wire logic cmd_valid,
    input fps_pkg::fps_cmd_t cmd,
    output logic cmd_ready,
    // Response
    output logic resp_valid,
    output fps_pkg::fps_resp_t resp,
    // Status
    output logic id_mode,
    output logic boot_locked,
    // Flash pins
    input wire logic [7:0] flash_dq_in,
    output fps_pkg::fps_pins_t flash_pins
);
    typedef enum logic [1:0] {
        FPS_IDLE = 2'b00,
        FPS_SEQ = 2'b01,
        FPS_POLL = 2'b11,
        FPS_READ = 2'b10
    } fps_st_t;

    typedef struct packed {
        fps_st_t st;
        fps_pkg::fps_cmd_t cmd;
        logic [2:0] step;
        logic prev_toggle;
        logic have_prev;
        logic [31:0] tmo;
        logic id_mode;
        logic boot_locked;
        logic cmd_ready;
        logic resp_valid;
        fps_pkg::fps_resp_t resp;
        logic bc_start;
        logic bc_write;
        logic bc_park;
        logic [17:0] bc_addr;
        logic [7:0] bc_data;
    } fps_host_t;

    fps_host_t s;
    fps_host_t next_s;
    logic bc_done;
    logic [7:0] bc_rdata;

    function automatic logic [2:0] seq_last(input fps_pkg::fps_op_t op);
        case (op)
            fps_pkg::FPS_OP_PROGRAM: seq_last = 3'h3;
            fps_pkg::FPS_OP_ERASE: seq_last = 3'h5;
            fps_pkg::FPS_OP_BOOT_LOCK: seq_last = 3'h5;
            default: seq_last = 3'h2;
        endcase
    endfunction : seq_last

    // One write of a command sequence: {address, data}
    function automatic logic [25:0] seq_word(input fps_pkg::fps_cmd_t c, input logic [2:0] k);
        logic [7:0] code;
        code = fps_pkg::CODE_ERASE_SETUP;
        case (c.op)
            fps_pkg::FPS_OP_PROGRAM: code = fps_pkg::CODE_PROGRAM;
            fps_pkg::FPS_OP_ID_ENTER: code = fps_pkg::CODE_ID_ENTER;
            fps_pkg::FPS_OP_ID_EXIT: code = fps_pkg::CODE_ID_EXIT;
            default: code = fps_pkg::CODE_ERASE_SETUP;
        endcase
        case (k)
            3'h0, 3'h3: seq_word = {fps_pkg::CMD_ADDR_A, fps_pkg::KEY_A};
            3'h1, 3'h4: seq_word = {fps_pkg::CMD_ADDR_B, fps_pkg::KEY_B};
            3'h2: seq_word = {fps_pkg::CMD_ADDR_A, code};
            default: seq_word = {fps_pkg::CMD_ADDR_A, (c.op == fps_pkg::FPS_OP_ERASE)
                                 ? fps_pkg::CODE_ERASE_CHIP : fps_pkg::CODE_BOOT_LOCK};
        endcase
        // Program data goes to the target address as the fourth write
        if (c.op == fps_pkg::FPS_OP_PROGRAM && k == 3'h3) begin
            seq_word = {c.addr, c.data};
        end
    endfunction : seq_word

    always_comb begin
        logic toggle_now;
        logic poll_ok;
        toggle_now = bc_rdata[fps_pkg::TOGGLE_BIT];
        poll_ok = (s.cmd.op != fps_pkg::FPS_OP_PROGRAM)
                  || (bc_rdata[fps_pkg::POLL_BIT] == s.cmd.data[fps_pkg::POLL_BIT]);
        next_s = s;
        next_s.bc_start = 1'b0;
        next_s.resp_valid = 1'b0;
        case (s.st)
            FPS_IDLE: begin
                if (cmd_valid && s.cmd_ready) begin
                    next_s.cmd = cmd;
                    next_s.cmd_ready = 1'b0;
                    next_s.step = 3'h0;
                    next_s.resp = '{data: 8'h00, error: 1'b0};
                    if (cmd.op == fps_pkg::FPS_OP_PROGRAM && s.boot_locked
                        && cmd.addr <= fps_pkg::BOOT_BLOCK_LAST) begin
                        // Locked boot block would silently ignore the write
                        next_s.resp.error = 1'b1;
                        next_s.resp_valid = 1'b1;
                        next_s.cmd_ready = 1'b1;
                    end else if (cmd.op == fps_pkg::FPS_OP_ID_READ && !s.id_mode) begin
                        next_s.resp.error = 1'b1;
                        next_s.resp_valid = 1'b1;
                        next_s.cmd_ready = 1'b1;
                    end else if (cmd.op == fps_pkg::FPS_OP_READ
                                 || cmd.op == fps_pkg::FPS_OP_ID_READ) begin
                        next_s.st = FPS_READ;
                        next_s.bc_start = 1'b1;
                        next_s.bc_write = 1'b0;
                        next_s.bc_addr = cmd.addr;
                        if (cmd.op == fps_pkg::FPS_OP_ID_READ) begin
                            // Upper lines low, bit 0 picks maker or part code
                            next_s.bc_addr = fps_pkg::ID_BASE_ADDR | 18'(cmd.addr[0]);
                        end
                    end else begin
                        next_s.st = FPS_SEQ;
                        next_s.bc_start = 1'b1;
                        next_s.bc_write = 1'b1;
                        next_s.bc_park = (cmd.op == fps_pkg::FPS_OP_ERASE);
                        {next_s.bc_addr, next_s.bc_data} =
                            seq_word('{op: cmd.op, addr: cmd.addr, data: cmd.data}, 3'h0);
                    end
                end
            end
            FPS_SEQ: begin
                if (bc_done) begin
                    if (s.step != seq_last(s.cmd.op)) begin
                        next_s.step = s.step + 3'h1;
                        next_s.bc_start = 1'b1;
                        {next_s.bc_addr, next_s.bc_data} = seq_word(s.cmd, s.step + 3'h1);
                    end else begin
                        next_s.bc_park = 1'b0;
                        case (s.cmd.op)
                            fps_pkg::FPS_OP_ID_ENTER: next_s.id_mode = 1'b1;
                            fps_pkg::FPS_OP_ID_EXIT: next_s.id_mode = 1'b0;
                            fps_pkg::FPS_OP_BOOT_LOCK: next_s.boot_locked = 1'b1;
                            default: next_s.id_mode = s.id_mode;
                        endcase
                        if (s.cmd.op == fps_pkg::FPS_OP_PROGRAM
                            || s.cmd.op == fps_pkg::FPS_OP_ERASE) begin
                            // Completion only from status, bounded by worst case
                            next_s.st = FPS_POLL;
                            next_s.have_prev = 1'b0;
                            next_s.tmo = (s.cmd.op == fps_pkg::FPS_OP_PROGRAM)
                                         ? 32'(PROG_TIMEOUT) : 32'(ERASE_TIMEOUT);
                            next_s.bc_start = 1'b1;
                            next_s.bc_write = 1'b0;
                            next_s.bc_addr = (s.cmd.op == fps_pkg::FPS_OP_PROGRAM)
                                             ? s.cmd.addr : fps_pkg::BOOT_BLOCK_FIRST;
                        end else begin
                            next_s.st = FPS_IDLE;
                            next_s.resp_valid = 1'b1;
                            next_s.cmd_ready = 1'b1;
                        end
                    end
                end
            end
            FPS_POLL: begin
                if (s.tmo != 32'h00000000) begin
                    next_s.tmo = s.tmo - 32'h00000001;
                end
                if (bc_done) begin
                    // Two equal toggle samples in a row, with bit 7 matching the data for a program, mean the device is idle
                    if (s.have_prev && toggle_now == s.prev_toggle && poll_ok) begin
                        next_s.st = FPS_IDLE;
                        next_s.resp.data = bc_rdata;
                        next_s.resp_valid = 1'b1;
                        next_s.cmd_ready = 1'b1;
                    end else if (s.tmo == 32'h00000000) begin
                        next_s.st = FPS_IDLE;
                        next_s.resp.data = bc_rdata;
                        next_s.resp.error = 1'b1;
                        next_s.resp_valid = 1'b1;
                        next_s.cmd_ready = 1'b1;
                    end else begin
                        next_s.prev_toggle = toggle_now;
                        next_s.have_prev = 1'b1;
                        // Same address again; each read toggles select and gate
                        next_s.bc_start = 1'b1;
                    end
                end
            end
            FPS_READ: begin
                if (bc_done) begin
                    next_s.st = FPS_IDLE;
                    next_s.resp.data = bc_rdata;
                    next_s.resp_valid = 1'b1;
                    next_s.cmd_ready = 1'b1;
                end
            end
            default: begin
                next_s.st = FPS_IDLE;
                next_s.cmd_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Reset stands for device power-up: array read, not id mode
            s <= '{st: FPS_IDLE, cmd: '{op: fps_pkg::FPS_OP_READ, addr: 18'h00000, data: 8'h00},
                   step: 3'h0, prev_toggle: 1'b0, have_prev: 1'b0, tmo: 32'h00000000,
                   id_mode: 1'b0, boot_locked: 1'b0, cmd_ready: 1'b1, resp_valid: 1'b0,
                   resp: '{data: 8'h00, error: 1'b0}, bc_start: 1'b0, bc_write: 1'b0,
                   bc_park: 1'b0, bc_addr: 18'h00000, bc_data: 8'h00};
        end else begin
            s <= next_s;
        end
    end

    fps_bus_cycle u_bus (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(s.bc_start),
        .is_write(s.bc_write),
        .oe_park_low(s.bc_park),
        .addr(s.bc_addr),
        .wdata(s.bc_data),
        .done(bc_done),
        .rdata(bc_rdata),
        .dq_in(flash_dq_in),
        .pins(flash_pins)
    );

    assign cmd_ready = s.cmd_ready;
    assign resp_valid = s.resp_valid;
    assign resp = s.resp;
    assign id_mode = s.id_mode;
    assign boot_locked = s.boot_locked;

endmodule : fps_host

// ==== verification/fps_host_monitor.sv ====
`timescale 1ns/1ps
module fps_host_monitor #(
    parameter int PROG_TIMEOUT = fps_pkg::PROG_TIMEOUT_CYC,
    parameter int ERASE_TIMEOUT = fps_pkg::ERASE_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Command and response
    input wire logic cmd_valid,
    input fps_pkg::fps_cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic resp_valid,
    input fps_pkg::fps_resp_t resp,
    // Status and pins
    input wire logic id_mode,
    input wire logic boot_locked,
    input wire logic [7:0] flash_dq_in,
    input fps_pkg::fps_pins_t flash_pins
);
    logic take;
    logic rd;
    logic rd_q;
    logic rd_start;
    logic rd_seen;
    logic we_q;
    logic we_fall;
    logic erasing;
    logic er_go;
    logic [2:0] widx;
    logic [2:0] er_rise;
    logic [7:0] gap;
    logic [17:0] rd_addr;
    assign take = cmd_valid && cmd_ready;
    assign rd = !flash_pins.ce_n && !flash_pins.oe_n && flash_pins.we_n;
    assign rd_start = rd && !rd_q;
    assign we_fall = !flash_pins.we_n && we_q;
    always_ff @(posedge sys_clk) begin
        rd_q <= rd && !rst;
        we_q <= flash_pins.we_n || rst;
        // Saturates so a long idle never wraps into a short gap
        gap <= rst ? 8'hFF : (rd ? 8'h00 : gap + {7'h00, gap != 8'hFF});
        if (rst || take) begin
            rd_seen <= 1'b0;
            widx <= 3'h0;
            er_go <= 1'b0;
            er_rise <= 3'h0;
            erasing <= !rst && cmd.op == fps_pkg::FPS_OP_ERASE;
        end else begin
            rd_seen <= rd_seen || rd_start;
            rd_addr <= rd_start ? flash_pins.addr : rd_addr;
            widx <= widx + {2'h0, we_fall && widx != 3'h7};
            er_go <= er_go || (we_fall && erasing);
            er_rise <= er_rise + {2'h0, erasing && flash_pins.we_n && !we_q};
        end
    end
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    AST_ERASE_GATE: assert property (
        er_go && er_rise < 3'h6 && flash_pins.oe_n |-> !flash_pins.we_n && !flash_pins.ce_n)
        else $error("Gate high outside write pulse in erase");
    AST_READ_GAP: assert property (
        rd_start |-> gap >= fps_pkg::OEHP_CYC)
        else $error("Strobe high time between reads too short");
    AST_POLL_ADDR: assert property (
        rd_start && rd_seen |-> flash_pins.addr == rd_addr)
        else $error("Polling address changed");
    AST_FIRST_WORD: assert property (
        we_fall && widx == 3'h0 |-> flash_pins.addr == fps_pkg::CMD_ADDR_A
            && flash_pins.dq_out == fps_pkg::KEY_A)
        else $error("First command word wrong");
    AST_SECOND_WORD: assert property (
        we_fall && widx == 3'h1 |-> flash_pins.addr == fps_pkg::CMD_ADDR_B
            && flash_pins.dq_out == fps_pkg::KEY_B)
        else $error("Second command word wrong");
    AST_BOOT_REFUSE: assert property (
        take && cmd.op == fps_pkg::FPS_OP_PROGRAM && boot_locked
            && cmd.addr <= fps_pkg::BOOT_BLOCK_LAST |=> resp_valid && resp.error && flash_pins.ce_n)
        else $error("Boot block program not refused");
    AST_ID_REFUSE: assert property (
        take && cmd.op == fps_pkg::FPS_OP_ID_READ && !id_mode |=> resp_valid && resp.error)
        else $error("Code read outside id mode not refused");
    AST_READY_DROP: assert property (
        take && cmd.op == fps_pkg::FPS_OP_READ |=> !cmd_ready [*8])
        else $error("Ready did not drop after take");
    AST_READ_LAT: assert property (
        take && cmd.op == fps_pkg::FPS_OP_READ |-> ##28 resp_valid && cmd_ready)
        else $error("Read answer late or early");
    COV_PROG: cover property (take && cmd.op == fps_pkg::FPS_OP_PROGRAM);
    COV_ERASE: cover property (take && cmd.op == fps_pkg::FPS_OP_ERASE);
    COV_ERR: cover property (resp_valid && resp.error);
endmodule : fps_host_monitor

bind fps_host fps_host_monitor #(
    .PROG_TIMEOUT(PROG_TIMEOUT),
    .ERASE_TIMEOUT(ERASE_TIMEOUT)
) fps_host_monitor_i (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp), .id_mode(id_mode),
    .boot_locked(boot_locked), .flash_dq_in(flash_dq_in), .flash_pins(flash_pins)
);

// ==== verification/fps_flash_model.sv ====
`timescale 1ns/1ps
module fps_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC6, // Arbitrary value
    parameter int PROG_CYC = 40,
    parameter int SLOW_CYC = 4000,
    parameter int ERASE_CYC = 600
) (
    // Clock and modes
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic power_loss,
    // Pins
    input fps_pkg::fps_pins_t pins,
    output logic [7:0] dq
);
    localparam logic [22:0] UNL_A = {fps_pkg::CMD_ADDR_A[14:0], fps_pkg::KEY_A};
    localparam logic [22:0] UNL_B = {fps_pkg::CMD_ADDR_B[14:0], fps_pkg::KEY_B};
    localparam logic [22:0] ER_SET = {fps_pkg::CMD_ADDR_A[14:0], fps_pkg::CODE_ERASE_SETUP};
    logic [7:0] mem [0:262143];
    logic [22:0] hist [0:2] = '{default: '0};
    logic [17:0] wa = '0;
    logic [7:0] wd = '0;
    logic we_q = 1'b1;
    logic rd_q = 1'b0;
    logic rd;
    logic arm = 1'b0;
    logic id_on = 1'b0;
    logic locked = 1'b0;
    logic tog = 1'b0;
    logic [7:0] pd = 8'hFF;
    logic [7:0] last = 8'h00;
    int busy = 0;
    initial begin
        for (int i = 0; i < 262144; i++) begin
            mem[i] = 8'hFF;
        end
    end
    assign rd = !pins.ce_n && !pins.oe_n && pins.we_n;
    // No pull on the data lines, so a released bus shows the inverse, not a stale value
    always_comb begin
        if (!rd) dq = ~last;
        else if (busy > 0) dq = {~pd[7], tog, 6'h00};
        else if (id_on && pins.addr[17:1] == 17'h0) dq = pins.addr[0] ? PART_CODE : MAKER_CODE;
        else dq = mem[pins.addr];
    end
    always @(posedge sys_clk) begin
        we_q <= pins.we_n;
        rd_q <= rd;
        last <= rd ? dq : last;
        busy <= (busy > 0) ? busy - 1 : 0;
        if (rd && !rd_q && busy > 0) tog <= ~tog;
        if (!pins.we_n && !pins.ce_n) begin
            wa <= pins.addr;
            wd <= pins.dq_out;
        end
        if (pins.we_n && !we_q) begin
            hist[2] <= hist[1];
            hist[1] <= hist[0];
            hist[0] <= {wa[14:0], wd};
            if (arm) begin
                arm <= 1'b0;
                if (!(locked && wa <= fps_pkg::BOOT_BLOCK_LAST)) begin
                    mem[wa] <= wd;
                    pd <= wd;
                    busy <= slow ? SLOW_CYC : PROG_CYC;
                end
            end else if (hist[1] == UNL_A && hist[0] == UNL_B && wa[14:0] == 15'h5555) begin
                case (wd)
                    fps_pkg::CODE_PROGRAM: arm <= 1'b1;
                    fps_pkg::CODE_ID_ENTER: id_on <= 1'b1;
                    fps_pkg::CODE_ID_EXIT: id_on <= 1'b0;
                    fps_pkg::CODE_BOOT_LOCK: locked <= locked || hist[2] == ER_SET;
                    fps_pkg::CODE_ERASE_CHIP: begin
                        if (hist[2] == ER_SET) begin
                            for (int i = 0; i < 262144; i++) mem[i] <= 8'hFF;
                            pd <= 8'hFF;
                            busy <= ERASE_CYC;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (power_loss) begin
            id_on <= 1'b0;
            arm <= 1'b0;
        end
    end
endmodule : fps_flash_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [2:0] op;
        logic [17:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
        logic [2:0] flg;
    } fps_row_t;
    localparam logic [7:0] MAKER = 8'hA5; // Arbitrary value
    localparam logic [7:0] PART = 8'h3C; // Arbitrary value
    // Flags: data checked, error expected, id mode expected
    localparam fps_row_t ROWS [16] = '{
        '{3'h1, 18'h12345, 8'h5A, 8'h00, 3'h0}, '{3'h0, 18'h12345, 8'h00, 8'h5A, 3'h4},
        '{3'h1, 18'h00010, 8'hC3, 8'h00, 3'h0}, '{3'h0, 18'h00010, 8'h00, 8'hC3, 3'h4},
        '{3'h6, 18'h00000, 8'h00, 8'h00, 3'h2}, '{3'h3, 18'h00000, 8'h00, 8'h00, 3'h1},
        '{3'h6, 18'h00000, 8'h00, MAKER, 3'h5}, '{3'h6, 18'h00001, 8'h00, PART, 3'h5},
        '{3'h4, 18'h00000, 8'h00, 8'h00, 3'h0}, '{3'h0, 18'h12345, 8'h00, 8'h5A, 3'h4},
        '{3'h5, 18'h00000, 8'h00, 8'h00, 3'h0}, '{3'h1, 18'h01FFF, 8'h00, 8'h00, 3'h2},
        '{3'h1, 18'h02000, 8'h77, 8'h00, 3'h0}, '{3'h0, 18'h02000, 8'h00, 8'h77, 3'h4},
        '{3'h2, 18'h00000, 8'h00, 8'h00, 3'h0}, '{3'h0, 18'h12345, 8'h00, 8'hFF, 3'h4}
    };
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    fps_pkg::fps_cmd_t cmd = '0;
    logic cmd_ready;
    logic resp_valid;
    fps_pkg::fps_resp_t resp;
    fps_pkg::fps_resp_t got;
    logic id_mode;
    logic boot_locked;
    logic [7:0] flash_dq;
    fps_pkg::fps_pins_t flash_pins;
    logic slow = 1'b0;
    logic power_loss = 1'b0;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    fps_host #(.PROG_TIMEOUT(2000), .ERASE_TIMEOUT(2000)) fps_host_i (
        .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp), .id_mode(id_mode),
        .boot_locked(boot_locked), .flash_dq_in(flash_dq), .flash_pins(flash_pins)
    );
    fps_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) fps_flash_model_i (
        .sys_clk(sys_clk), .slow(slow), .power_loss(power_loss), .pins(flash_pins), .dq(flash_dq)
    );
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run_cmd(input logic [2:0] op, input logic [17:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd = '{fps_pkg::fps_op_t'(op), addr, data};
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        // A refusal answers at once, so look before waiting
        for (int n = 0; n < 8000 && resp_valid !== 1'b1; n++) @(negedge sys_clk);
        check({7'h00, resp_valid}, 8'h01);
        got = resp;
    endtask : run_cmd
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            final_report();
        end
    end
    initial begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            run_cmd(ROWS[i].op, ROWS[i].addr, ROWS[i].data);
            check({7'h00, got.error}, {7'h00, ROWS[i].flg[1]});
            if (ROWS[i].flg[2]) check(got.data, ROWS[i].exp);
            check({7'h00, id_mode}, {7'h00, ROWS[i].flg[0]});
        end
        check({7'h00, boot_locked}, 8'h01);
        // Device stays busy past the host limit, so the poll must give up
        slow = 1'b1;
        run_cmd(3'h1, 18'h20000, 8'h81);
        check({7'h00, got.error}, 8'h01);
        repeat (2500) @(negedge sys_clk);
        slow = 1'b0;
        run_cmd(3'h0, 18'h20000, 8'h00);
        check(got.data, 8'h81);
        run_cmd(3'h3, 18'h00000, 8'h00);
        rst = 1'b1;
        power_loss = 1'b1;
        @(negedge sys_clk);
        check({cmd_ready, resp_valid, id_mode, boot_locked, flash_pins.ce_n, flash_pins.oe_n,
            flash_pins.we_n, flash_pins.dq_oe}, 8'h8E);
        repeat (9) @(negedge sys_clk);
        rst = 1'b0;
        power_loss = 1'b0;
        run_cmd(3'h0, 18'h00000, 8'h00);
        check(got.data, 8'hFF);
        // Host forgot the lockout but the device did not
        run_cmd(3'h1, 18'h00020, 8'h11);
        check({7'h00, got.error}, 8'h01);
        run_cmd(3'h0, 18'h00020, 8'h00);
        check(got.data, 8'hFF);
        final_report();
    end
endmodule : testbench
